/* design/ipvu_top.v */
`timescale 1ns/1ps
`include "ipvu_consts.vh"

// Operation
// RULE_01: group-0 high byte, bit 7 unused
// RULE_02: group-1 low byte maps capture/compare/overflow
// RULE_03: fixed service order among equal levels
// RULE_04: each source has fixed vector, step 8
// RULE_05: group-1 high byte pairs group-1 low
// RULE_06: group-1 high uses group-1 bit positions
// RULE_07: high and low bit form level 0-3
// RULE_08: only higher level than in-service taken
// RULE_09: per-source enables plus global enable gate
module ipvu_top (
    // Clock and reset
    input wire clk_sys,
    input wire reset,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // Source request flags, vector order
    input wire [14:0] src_req,
    // Processor core side
    output reg core_irq,
    output reg [15:0] core_vector,
    output reg [1:0] core_level,
    input wire core_ack,
    input wire core_reti,
    output reg [14:0] src_taken,
    // Event interrupt
    output reg evt_irq
);

    // Software registers
    reg [7:0] enable_g0;
    reg [7:0] enable_g1;
    reg [7:0] lvl_lo_g0;
    reg [6:0] lvl_hi_g0;
    reg [7:0] lvl_lo_g1;
    reg [7:0] lvl_hi_g1;
    reg [2:0] evt_status;
    reg [2:0] evt_mask;
    // Service state
    reg [3:0] in_service;
    reg [3:0] offer_idx;
    // Bus phase state
    reg wr_pend;
    reg rd_pend;
    reg [11:0] bus_addr;

    // RULE_02: group-1 byte spread to vector order
    // RULE_06: same spread for group-1 high
    function [14:0] ipvu_spread;
        input [7:0] g0;
        input [7:0] g1;
        begin
            ipvu_spread = {g1[7], g1[6:4], g0[6], g1[3:0], g0[5:0]};
        end
    endfunction

    // Highest level currently in service plus one, zero when none
    function [2:0] ipvu_top_level;
        input [3:0] isv;
        begin
            if (isv[3]) begin
                ipvu_top_level = 3'h4;
            end else if (isv[2]) begin
                ipvu_top_level = 3'h3;
            end else if (isv[1]) begin
                ipvu_top_level = 3'h2;
            end else if (isv[0]) begin
                ipvu_top_level = 3'h1;
            end else begin
                ipvu_top_level = 3'h0;
            end
        end
    endfunction

    wire [14:0] src_en;
    wire [14:0] src_hi;
    wire [14:0] src_lo;
    wire [14:0] gated_req;
    wire global_en;
    wire any;
    wire [3:0] win_idx;
    wire [1:0] win_level;
    wire [2:0] cur_top;
    wire accept;
    wire take;
    wire ret;
    wire addr_phase;
    wire [2:0] evt_set;
    wire stat_rd;

    // RULE_09: source and global enables
    assign global_en = enable_g0[`IPVU_G0_GLOBAL_EN_BIT];
    assign src_en = ipvu_spread({1'b0, enable_g0[6:0]}, enable_g1);
    assign gated_req = src_req & src_en & {15{global_en}};
    // RULE_01: group-0 high bits per source
    // RULE_05: group-1 high pairs with low
    assign src_hi = ipvu_spread({1'b0, lvl_hi_g0}, lvl_hi_g1);
    assign src_lo = ipvu_spread(lvl_lo_g0, lvl_lo_g1);

    // Priority resolution
    ipvu_resolver u_resolver (
        .req(gated_req),
        .lvl_hi(src_hi),
        .lvl_lo(src_lo),
        .any(any),
        .win_idx(win_idx),
        .win_level(win_level)
    );

    // RULE_07: level index compared against in-service
    // RULE_08: strictly higher level preempts
    assign cur_top = ipvu_top_level(in_service);
    assign accept = any && ({1'b0, win_level} >= cur_top) &&
        !(in_service != 4'h0 && {1'b0, win_level} < cur_top) &&
        !(cur_top != 3'h0 && {1'b0, win_level} == cur_top - 3'h1);
    assign take = core_ack && core_irq;
    assign ret = core_reti && (in_service != 4'h0);

    // Offer to the core, dropped in the cycle after it is taken
    always @(posedge clk_sys) begin
        if (reset) begin
            core_irq <= 1'b0;
            core_vector <= `IPVU_VEC_BASE;
            core_level <= 2'b00;
            offer_idx <= 4'h0;
        end else begin
            core_irq <= accept && !take;
            if (!take) begin
                offer_idx <= win_idx;
                core_level <= win_level;
                // RULE_04: vector base plus eight per source
                core_vector <= `IPVU_VEC_BASE + {9'h000, win_idx, 3'b000};
            end
        end
    end

    // RULE_08: in-service stack, nested return
    always @(posedge clk_sys) begin
        if (reset) begin
            in_service <= 4'h0;
            src_taken <= 15'h0000;
        end else begin
            src_taken <= 15'h0000;
            if (take) begin
                in_service <= in_service | (4'h1 << core_level);
                src_taken <= 15'h0001 << offer_idx;
            end else if (ret) begin
                in_service <= in_service & ~(4'h1 << (cur_top - 3'h1));
            end
        end
    end

    // Events: taken, preemption, return
    assign evt_set[`IPVU_EVT_TAKEN] = take;
    assign evt_set[`IPVU_EVT_PREEMPT] = take && (in_service != 4'h0);
    assign evt_set[`IPVU_EVT_RETURN] = ret && !take;
    assign stat_rd = rd_pend && (bus_addr == `IPVU_BYTE_ADDR(`IPVU_IDX_EVT_STATUS));

    // Sticky status, cleared by read, set wins
    always @(posedge clk_sys) begin
        if (reset) begin
            evt_status <= `IPVU_RST_EVT;
            evt_irq <= 1'b0;
        end else begin
            evt_status <= (stat_rd ? 3'h0 : evt_status) | evt_set;
            evt_irq <= |((((stat_rd ? 3'h0 : evt_status) | evt_set)) & evt_mask);
        end
    end

    // AHB address phase accepted
    assign addr_phase = hsel && hready && htrans[`IPVU_HTRANS_NONSEQ_BIT];

    // Bus phase tracking; reads take one wait state
    always @(posedge clk_sys) begin
        if (reset) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            bus_addr <= 12'h000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
            wr_pend <= addr_phase && hwrite;
            rd_pend <= addr_phase && !hwrite;
            hreadyout <= !(addr_phase && !hwrite);
            if (addr_phase) begin
                bus_addr <= haddr[11:0];
            end
        end
    end

    // Register writes in the data phase
    always @(posedge clk_sys) begin
        if (reset) begin
            enable_g0 <= `IPVU_RST_BYTE;
            enable_g1 <= `IPVU_RST_BYTE;
            lvl_lo_g0 <= `IPVU_RST_BYTE;
            lvl_hi_g0 <= 7'h00;
            lvl_lo_g1 <= `IPVU_RST_BYTE;
            lvl_hi_g1 <= `IPVU_RST_BYTE;
            evt_mask <= `IPVU_RST_EVT;
        end else if (wr_pend) begin
            if (bus_addr == `IPVU_BYTE_ADDR(`IPVU_IDX_ENABLE_G0)) begin
                enable_g0 <= hwdata[7:0];
            end else if (bus_addr == `IPVU_BYTE_ADDR(`IPVU_IDX_ENABLE_G1)) begin
                enable_g1 <= hwdata[7:0];
            end else if (bus_addr == `IPVU_BYTE_ADDR(`IPVU_IDX_LVL_LO_G0)) begin
                lvl_lo_g0 <= {1'b0, hwdata[6:0]};
            end else if (bus_addr == `IPVU_BYTE_ADDR(`IPVU_IDX_LVL_HI_G0)) begin
                lvl_hi_g0 <= hwdata[6:0];
            end else if (bus_addr == `IPVU_BYTE_ADDR(`IPVU_IDX_LVL_LO_G1)) begin
                lvl_lo_g1 <= hwdata[7:0];
            end else if (bus_addr == `IPVU_BYTE_ADDR(`IPVU_IDX_LVL_HI_G1)) begin
                lvl_hi_g1 <= hwdata[7:0];
            end else if (bus_addr == `IPVU_BYTE_ADDR(`IPVU_IDX_EVT_MASK)) begin
                evt_mask <= hwdata[2:0];
            end
        end
    end

    // Read data, loaded in the wait state
    always @(posedge clk_sys) begin
        if (reset) begin
            hrdata <= 32'h00000000;
        end else if (rd_pend) begin
            if (bus_addr == `IPVU_BYTE_ADDR(`IPVU_IDX_ENABLE_G0)) begin
                hrdata <= {24'h000000, enable_g0};
            end else if (bus_addr == `IPVU_BYTE_ADDR(`IPVU_IDX_ENABLE_G1)) begin
                hrdata <= {24'h000000, enable_g1};
            end else if (bus_addr == `IPVU_BYTE_ADDR(`IPVU_IDX_LVL_LO_G0)) begin
                hrdata <= {24'h000000, lvl_lo_g0};
            end else if (bus_addr == `IPVU_BYTE_ADDR(`IPVU_IDX_LVL_HI_G0)) begin
                hrdata <= {25'h0000000, lvl_hi_g0};
            end else if (bus_addr == `IPVU_BYTE_ADDR(`IPVU_IDX_LVL_LO_G1)) begin
                hrdata <= {24'h000000, lvl_lo_g1};
            end else if (bus_addr == `IPVU_BYTE_ADDR(`IPVU_IDX_LVL_HI_G1)) begin
                hrdata <= {24'h000000, lvl_hi_g1};
            end else if (bus_addr == `IPVU_BYTE_ADDR(`IPVU_IDX_EVT_STATUS)) begin
                hrdata <= {29'h00000000, evt_status};
            end else if (bus_addr == `IPVU_BYTE_ADDR(`IPVU_IDX_EVT_MASK)) begin
                hrdata <= {29'h00000000, evt_mask};
            end else if (bus_addr == `IPVU_BYTE_ADDR(`IPVU_IDX_IN_SERVICE)) begin
                hrdata <= {28'h0000000, in_service};
            end else if (bus_addr == `IPVU_BYTE_ADDR(`IPVU_IDX_OFFER)) begin
                hrdata <= {9'h000, core_irq, core_level, offer_idx, core_vector};
            end else begin
                hrdata <= 32'h00000000;
            end
        end
    end

endmodule

/* pkg/ipvu_consts.vh */
`ifndef IPVU_CONSTS_VH
`define IPVU_CONSTS_VH

// Register indexes; byte address is four times the index
`define IPVU_IDX_ENABLE_G0 8'ha8
`define IPVU_IDX_LVL_LO_G0 8'hb8
`define IPVU_IDX_LVL_HI_G0 8'hb7
`define IPVU_IDX_ENABLE_G1 8'he8
`define IPVU_IDX_LVL_LO_G1 8'hf8
`define IPVU_IDX_LVL_HI_G1 8'hf7
`define IPVU_IDX_EVT_STATUS 8'hc0
`define IPVU_IDX_EVT_MASK 8'hc1
`define IPVU_IDX_IN_SERVICE 8'hc2
`define IPVU_IDX_OFFER 8'hc3

// Byte address of a register index
`define IPVU_BYTE_ADDR(idx) {2'b00, (idx), 2'b00}

// Reset values
`define IPVU_RST_BYTE 8'h00
`define IPVU_RST_EVT 3'h0

// Field positions
`define IPVU_G0_UNUSED_BIT 7
`define IPVU_G0_GLOBAL_EN_BIT 7
`define IPVU_EVT_TAKEN 0
`define IPVU_EVT_PREEMPT 1
`define IPVU_EVT_RETURN 2

// Vector table
`define IPVU_VEC_BASE 16'h0003
`define IPVU_NUM_SRC 15

// AHB encodings
`define IPVU_HTRANS_NONSEQ_BIT 1

`endif

/* design/ipvu_resolver.v */
`timescale 1ns/1ps
`include "ipvu_consts.vh"

module ipvu_resolver (
    // Gated requests and their two-bit levels
    input wire [14:0] req,
    input wire [14:0] lvl_hi,
    input wire [14:0] lvl_lo,
    // Winner
    output reg any,
    output reg [3:0] win_idx,
    output reg [1:0] win_level
);

    // Source index in vector order, ranked within a level
    function [3:0] ipvu_order;
        input [3:0] rank;
        begin
            case (rank)
                4'h0: ipvu_order = 4'h0;
                4'h1: ipvu_order = 4'h5;
                4'h2: ipvu_order = 4'ha;
                4'h3: ipvu_order = 4'h1;
                4'h4: ipvu_order = 4'h6;
                4'h5: ipvu_order = 4'hb;
                4'h6: ipvu_order = 4'h2;
                4'h7: ipvu_order = 4'h7;
                4'h8: ipvu_order = 4'hc;
                4'h9: ipvu_order = 4'h3;
                4'ha: ipvu_order = 4'h8;
                4'hb: ipvu_order = 4'hd;
                4'hc: ipvu_order = 4'h4;
                4'hd: ipvu_order = 4'h9;
                default: ipvu_order = 4'he;
            endcase
        end
    endfunction

    integer r;
    reg [3:0] s;
    reg [1:0] lv;

    // RULE_03: fixed order ties
    always @* begin
        any = 1'b0;
        win_idx = 4'h0;
        win_level = 2'b00;
        s = 4'h0;
        lv = 2'b00;
        for (r = 0; r < `IPVU_NUM_SRC; r = r + 1) begin
            s = ipvu_order(r[3:0]);
            lv = {lvl_hi[s], lvl_lo[s]};
            if (req[s] && (!any || lv > win_level)) begin
                any = 1'b1;
                win_idx = s;
                win_level = lv;
            end
        end
    end

endmodule

/* testbench/ipvu_core_model.sv */
`timescale 1ns/1ps
// Core model: takes offers after a lag and returns in nesting order
module ipvu_core_model (
    // Clock and reset
    input wire clk_sys,
    input wire reset,
    // Offer side
    input wire core_irq,
    input wire ret_go,
    input wire [1:0] lag,
    output logic core_ack,
    output logic core_reti,
    output logic [3:0] depth
);
    int w;
    // Ack and return pulses, one cycle each
    always @(posedge clk_sys) begin
        core_ack <= 1'b0;
        core_reti <= 1'b0;
        if (reset) begin
            depth <= 4'h0;
            w <= 0;
        end else begin
            if (core_ack && core_irq) depth <= depth + 4'h1;
            else if (core_reti) depth <= depth - 4'h1;
            if (!core_ack && !core_reti) begin
                if (core_irq && w >= lag) begin
                    core_ack <= 1'b1;
                    w <= 0;
                end else if (core_irq) w <= w + 1;
                else if (ret_go && depth != 4'h0) core_reti <= 1'b1;
            end
        end
    end
endmodule

/* testbench/ipvu_checker.sv */
`timescale 1ns/1ps
module ipvu_checker (
    // Clock, reset and bus
    input wire clk_sys,
    input wire reset,
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    // Core side
    input wire [14:0] src_req,
    input wire core_irq,
    input wire [15:0] core_vector,
    input wire core_ack,
    input wire [14:0] src_taken
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    property p_rd_wait; hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
    property p_wr_go; hsel && hready && htrans[1] && hwrite |=> hreadyout; endproperty
    a_wr_go: assert property (p_wr_go) else $error("write stalled");
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    property p_take_drop; core_ack && core_irq |=> !core_irq; endproperty
    a_take_drop: assert property (p_take_drop) else $error("offer kept after take");
    property p_take_one; core_ack && core_irq |=> $onehot(src_taken); endproperty
    a_take_one: assert property (p_take_one) else $error("taken pulse missing");
    property p_pulse; src_taken != 15'h0 |=> src_taken == 15'h0; endproperty
    a_pulse: assert property (p_pulse) else $error("taken pulse too long");
    property p_vec; core_irq |-> core_vector[2:0] == 3'h3 && core_vector[15:7] == 9'h0
        && core_vector[6:3] != 4'hf; endproperty
    a_vec: assert property (p_vec) else $error("vector off table");
    property p_req; src_taken != 15'h0 |-> |(src_taken & $past(src_req)); endproperty
    a_req: assert property (p_req) else $error("taken without request");
    property p_idle; (src_req == 15'h0) [*2] |=> !core_irq; endproperty
    a_idle: assert property (p_idle) else $error("offer without request");
endmodule
bind ipvu_top ipvu_checker i_chk (.clk_sys(clk_sys), .reset(reset), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .src_req(src_req), .core_irq(core_irq), .core_vector(core_vector), .core_ack(core_ack),
    .src_taken(src_taken));

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`include "ipvu_consts.vh"
module tb_top;
    logic clk_sys = 0, reset = 1, hsel = 0, hwrite = 0, ret_go = 0, ph_rd = 0;
    logic [1:0] htrans = 0, lag = 0;
    logic [31:0] haddr = 0, hwdata = 0;
    logic [14:0] src_req = 0;
    wire [31:0] hrdata;
    wire hreadyout, hresp, core_irq, core_ack, core_reti, evt_irq;
    wire [15:0] core_vector;
    wire [1:0] core_level;
    wire [14:0] src_taken;
    wire [3:0] depth;
    int error_cnt = 0, checks = 0, cyc = 0;
    logic [31:0] q_rd[$];
    logic [17:0] q_vec[$];
    byte ord[15] = '{0, 5, 10, 1, 6, 11, 2, 7, 12, 3, 8, 13, 4, 9, 14};
    byte unsigned ridx[10] = '{`IPVU_IDX_ENABLE_G0, `IPVU_IDX_LVL_LO_G0, `IPVU_IDX_LVL_HI_G0,
        `IPVU_IDX_ENABLE_G1, `IPVU_IDX_LVL_LO_G1, `IPVU_IDX_LVL_HI_G1, `IPVU_IDX_EVT_STATUS,
        `IPVU_IDX_EVT_MASK, `IPVU_IDX_IN_SERVICE, 8'h10};
    byte unsigned widx[7] = '{8'hb7, 8'hb8, 8'hf8, 8'hf7, 8'hc2, 8'hc1, 8'h10};
    byte unsigned wexp[7] = '{8'h7f, 8'h7f, 8'hff, 8'hff, 8'h00, 8'h07, 8'h00};
    // Clock
    initial forever #2.5 clk_sys = ~clk_sys;
    ipvu_top i_dut (.clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .src_req(src_req),
        .core_irq(core_irq), .core_vector(core_vector), .core_level(core_level),
        .core_ack(core_ack), .core_reti(core_reti), .src_taken(src_taken), .evt_irq(evt_irq));
    ipvu_core_model i_core (.clk_sys(clk_sys), .reset(reset), .core_irq(core_irq),
        .ret_go(ret_go), .lag(lag), .core_ack(core_ack), .core_reti(core_reti), .depth(depth));
    task automatic conclude;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmp(input string k, input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error t=%0t %s got %h exp %h", $time, k, g, e);
        end
    endtask
    task automatic rdy;
        @(negedge clk_sys);
        while (hreadyout !== 1'b1) @(negedge clk_sys);
        @(posedge clk_sys);
    endtask
    // Single word transfer; read value d is noted as expected
    task automatic bus(input [7:0] idx, input w, input [31:0] d);
        haddr <= `IPVU_BYTE_ADDR(idx);
        htrans <= 2'b10;
        hwrite <= w;
        hsel <= 1'b1;
        rdy;
        htrans <= 2'b00;
        hwdata <= d;
        if (!w) q_rd.push_back(d);
        rdy;
    endtask
    function automatic [7:0] pk0(input [14:0] x);
        pk0 = {1'b0, x[10], x[5:0]};
    endfunction
    function automatic [7:0] pk1(input [14:0] x);
        pk1 = {x[14:11], x[9:6]};
    endfunction
    task automatic setlv(input [14:0] h, input [14:0] l);
        bus(`IPVU_IDX_LVL_HI_G0, 1, pk0(h));
        bus(`IPVU_IDX_LVL_LO_G0, 1, pk0(l));
        bus(`IPVU_IDX_LVL_HI_G1, 1, pk1(h));
        bus(`IPVU_IDX_LVL_LO_G1, 1, pk1(l));
        bus(`IPVU_IDX_ENABLE_G1, 1, 8'hff);
        bus(`IPVU_IDX_ENABLE_G0, 1, 8'hff);
    endtask
    task automatic wdep(input [3:0] d);
        for (int i = 0; i < 500 && depth !== d; i++) @(posedge clk_sys);
    endtask
    // All sources raised at once; service order noted
    task automatic serve(input [14:0] h, input [14:0] l, input [14:0] e);
        setlv(h, l);
        bus(`IPVU_IDX_ENABLE_G1, 1, pk1(e));
        bus(`IPVU_IDX_ENABLE_G0, 1, pk0(e) | 8'h80);
        for (int v = 3; v >= 0; v--)
            foreach (ord[k])
                if (e[ord[k]] && {h[ord[k]], l[ord[k]]} == v)
                    q_vec.push_back({v[1:0], 16'h0003 + 16'(8 * ord[k])});
        ret_go <= 1;
        src_req <= 15'h7fff;
        // Let the raised flags land before testing them
        @(posedge clk_sys);
        for (int i = 0; i < 2000 && (src_req & e) != 0; i++) @(posedge clk_sys);
        wdep(0);
        cmp("left", q_vec.size(), 0);
        src_req <= 0;
        bus(`IPVU_IDX_EVT_STATUS, 0, 5);
        $display("test serve done");
    endtask
    // Monitor: read data, offers taken, flags dropped
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            conclude;
        end
        if (ph_rd && hreadyout) cmp("rd", hrdata, q_rd.pop_front());
        if (hreadyout) ph_rd <= hsel && htrans[1] && !hwrite;
        if (core_ack && core_irq)
            cmp("vec", {core_level, core_vector}, q_vec.size() ? q_vec.pop_front() : 18'h3ffff);
        if (src_taken != 0) src_req <= src_req & ~src_taken;
    end
    initial begin
        void'($urandom(32'hbca15a8a));
        repeat (2) @(posedge clk_sys);
        reset <= 0;
        foreach (ridx[i]) bus(ridx[i], 0, 0);
        bus(`IPVU_IDX_OFFER, 0, 3);
        foreach (widx[i]) begin
            bus(widx[i], 1, 8'hff);
            bus(widx[i], 0, wexp[i]);
        end
        bus(`IPVU_IDX_ENABLE_G1, 1, 8'hff);
        bus(`IPVU_IDX_ENABLE_G0, 1, 8'h7f);
        src_req <= 15'h7fff;
        repeat (10) @(posedge clk_sys);
        cmp("irq", core_irq, 0);
        src_req <= 0;
        $display("test regs done");
        serve(0, 0, 15'h7fff);
        repeat (3) begin
            lag <= $urandom % 3;
            serve($urandom, $urandom, $urandom | 1);
        end
        ret_go <= 0;
        setlv(0, 0);
        q_vec.push_back({2'd0, 16'h0003});
        src_req <= 15'h0001;
        wdep(1);
        // Clear of the taken flag lands first
        @(posedge clk_sys);
        src_req <= 15'h4000;
        repeat (10) @(posedge clk_sys);
        q_vec.push_back({2'd3, 16'h0073}); // preempt
        // Overflow masked while its level bits change
        bus(`IPVU_IDX_ENABLE_G1, 1, 8'h7f);
        setlv(15'h4000, 15'h4000);
        wdep(2);
        bus(`IPVU_IDX_EVT_STATUS, 0, 3);
        bus(`IPVU_IDX_EVT_STATUS, 0, 0);
        bus(`IPVU_IDX_IN_SERVICE, 0, 9);
        bus(`IPVU_IDX_EVT_MASK, 1, 4);
        cmp("evt", evt_irq, 0);
        ret_go <= 1;
        wdep(0);
        repeat (3) @(posedge clk_sys);
        cmp("evt", evt_irq, 1);
        bus(`IPVU_IDX_EVT_STATUS, 0, 4);
        repeat (3) @(posedge clk_sys);
        cmp("evt", evt_irq, 0);
        $display("test nest done");
        conclude;
    end
endmodule
